// file: bench/low_power_wakeup_sleep_timer_test.sv
`timescale 1ns/10ps

module low_power_wakeup_sleep_timer_test
  import sleep_timer_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;

  logic        clk, reset, xosc, rc, sel, fast, cal_v;
  sfr_req_s    req;
  power_mode_e pm;
  logic [5:0]  cal_r, trim;
  logic [7:0]  rdata;
  logic        wake_req, irq, dma;
  int          errors, n_tests, dma_cnt;

  row_s rows [15] = '{
    '{1'b0, ADDR_EVT_LOW, 8'h00, 8'h6B}, '{1'b0, ADDR_EVT_HIGH, 8'h00, 8'h87},
    '{1'b0, ADDR_CTRL, 8'h00, 8'h70}, '{1'b0, ADDR_IRQ_CTRL, 8'h00, 8'h00},
    '{1'b0, ADDR_CNT_LOW, 8'h00, 8'h00}, '{1'b0, ADDR_CNT_HIGH, 8'h00, 8'h00},
    '{1'b0, 8'hA0, 8'h00, 8'h00}, '{1'b1, ADDR_EVT_LOW, 8'h55, 8'h55},
    '{1'b1, ADDR_EVT_HIGH, 8'hAA, 8'hAA}, '{1'b1, ADDR_IRQ_CTRL, 8'hFF, 8'h10},
    '{1'b1, ADDR_CTRL, 8'h07, 8'h03}, '{1'b1, ADDR_CTRL, 8'h00, 8'h00},
    '{1'b1, ADDR_CNT_LOW, 8'h12, 8'h04}, '{1'b0, ADDR_CNT_HIGH, 8'h00, 8'h00},
    '{1'b1, 8'hA7, 8'h5A, 8'h00}};

  sleep_timer u_sleep_timer (
    .clk(clk), .reset(reset), .sfr_req(req), .sfr_rdata(rdata),
    .xosc_32k_in(xosc), .low_power_rc_oscillator_in(rc), .sleep_clk_sel(sel), .power_mode(pm),
    .fast_xosc_running(fast), .rc_cal_valid(cal_v), .rc_cal_result(cal_r),
    .rc_cal_trim(trim), .wake_request(wake_req), .wake_irq(irq),
    .wake_dma_trigger(dma)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dma === 1'b1) dma_cnt <= dma_cnt + 1;
  end

  // ========================================================================
  // helpers
  // ========================================================================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    check($sformatf("reg %h", a), rdata, e);
    req.rd = 1'b0;
  endtask : rchk

  // n sleep clock periods on the crystal (1) or rc (0) pin
  task automatic tick(input logic s, input int n);
    repeat (n) begin
      @(negedge clk);
      if (s) xosc = 1'b1;
      else rc = 1'b1;
      repeat (6) @(negedge clk);
      xosc = 1'b0;
      rc = 1'b0;
      repeat (5) @(negedge clk);
    end
  endtask : tick

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end

  // ========================================================================
  // main sequence
  // ========================================================================
  initial begin
    reset = 1'b1;
    req = '0;
    xosc = 1'b0;
    rc = 1'b0;
    sel = 1'b1;
    fast = 1'b0;
    cal_v = 1'b0;
    cal_r = 6'h00;
    pm = pm_active;
    dma_cnt = 0;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    check("idle outputs", {rdata, wake_req, irq, dma, trim}, '0);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    $display("register table done");
    tick(1'b1, 3);
    rchk(ADDR_CNT_LOW, 8'h07);
    rchk(ADDR_CNT_HIGH, 8'h00);
    wr(ADDR_CTRL, 8'h01);
    rchk(ADDR_CNT_LOW, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    rchk(ADDR_CNT_LOW, 8'h07);
    pm = deepest_power_mode;
    tick(1'b1, 2);
    pm = pm_active;
    rchk(ADDR_CNT_LOW, 8'h07);
    sel = 1'b0;
    tick(1'b1, 1);
    tick(1'b0, 1);
    sel = 1'b1;
    rchk(ADDR_CNT_LOW, 8'h08);
    $display("counting done");
    wr(ADDR_EVT_HIGH, 8'h00);
    wr(ADDR_EVT_LOW, 8'h06);
    repeat (3) @(negedge clk);
    check("write below event", dma_cnt, 1);
    rchk(ADDR_CNT_LOW, 8'h00);
    rchk(ADDR_IRQ_CTRL, 8'h11);
    check("irq masked on", irq, 1'b1);
    wr(ADDR_IRQ_CTRL, 8'h10);
    rchk(ADDR_IRQ_CTRL, 8'h10);
    check("irq cleared", irq, 1'b0);
    wr(ADDR_IRQ_CTRL, 8'h00);
    wr(ADDR_EVT_HIGH, 8'h01);
    wr(ADDR_EVT_LOW, 8'h82);
    @(negedge clk);
    xosc = 1'b1;
    pm = power_mode_two;
    repeat (6) @(negedge clk);
    xosc = 1'b0;
    repeat (5) @(negedge clk);
    tick(1'b1, 384);
    check("no early event", dma_cnt, 1);
    tick(1'b1, 1);
    check("event after entry", dma_cnt, 2);
    check("wake request", wake_req, 1'b1);
    check("irq masked off", irq, 1'b0);
    rchk(ADDR_IRQ_CTRL, 8'h01);
    pm = pm_active;
    repeat (2) @(negedge clk);
    check("wake released", wake_req, 1'b0);
    $display("event done");
    wr(ADDR_EVT_HIGH, 8'h00);
    wr(ADDR_EVT_LOW, 8'h06);
    wr(ADDR_CTRL, 8'h01);
    tick(1'b1, 191);
    check("res1 early", dma_cnt, 2);
    tick(1'b1, 1);
    check("res1 event", dma_cnt, 3);
    $display("resolution done");
    pm = power_mode_zero;
    cal_r = 6'h2A;
    cal_v = 1'b1;
    fast = 1'b1;
    repeat (2) @(negedge clk);
    check("trim capture", trim, 6'h2A);
    pm = power_mode_one;
    cal_r = 6'h15;
    repeat (3) @(negedge clk);
    check("trim held", trim, 6'h2A);
    $display("trim done");
    reset = 1'b1;
    @(negedge clk);
    check("reset trim", trim, 6'h00);
    reset = 1'b0;
    rchk(ADDR_EVT_LOW, 8'h6B);
    rchk(ADDR_EVT_HIGH, 8'h87);
    $display("reset done");
    final_report();
  end
endmodule : low_power_wakeup_sleep_timer_test

// file: bench/sleep_timer_props.sv
`timescale 1ns/10ps

// ==========================================================================
// checker on the top ports
// ==========================================================================
module sleep_timer_props
  import sleep_timer_pkg::*;
#(
  parameter int unsigned CAL_WIDTH = 6
) (
  input wire logic                 clk,
  input wire logic                 reset,
  input wire sfr_req_s             sfr_req,
  input wire logic [7:0]           sfr_rdata,
  input wire power_mode_e          power_mode,
  input wire logic                 fast_xosc_running,
  input wire logic                 rc_cal_valid,
  input wire logic [CAL_WIDTH-1:0] rc_cal_result,
  input wire logic [CAL_WIDTH-1:0] rc_cal_trim,
  input wire logic                 wake_request,
  input wire logic                 wake_irq,
  input wire logic                 wake_dma_trigger
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic cal_ok;
  assign cal_ok = rc_cal_valid && fast_xosc_running &&
                  (power_mode inside {pm_active, power_mode_zero});

  a_dma_one_pulse: assert property (wake_dma_trigger |=> !wake_dma_trigger)
    else $error("dma trigger longer than one cycle");
  a_no_deep_event: assert property ((power_mode == deepest_power_mode)[*2]
    |-> !wake_dma_trigger)
    else $error("event while in deepest mode");
  a_wake_on_event: assert property (wake_dma_trigger &&
    $past(power_mode) inside {power_mode_zero, power_mode_one, power_mode_two}
    |-> wake_request)
    else $error("no wake request on light sleep event");
  a_wake_hold: assert property (wake_request && power_mode != pm_active
    |=> wake_request)
    else $error("wake request dropped early");
  a_wake_release: assert property (wake_request && power_mode == pm_active
    |=> !wake_request)
    else $error("wake request held in active mode");
  a_trim_capture: assert property (cal_ok |=> rc_cal_trim == $past(rc_cal_result))
    else $error("trim not captured");
  a_trim_hold: assert property (!cal_ok |=> $stable(rc_cal_trim))
    else $error("trim changed without calibration");
  a_rdata_idle: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero when idle");
  a_ctrl_reset_bit: assert property (sfr_req.rd && sfr_req.addr == ADDR_CTRL
    |=> sfr_rdata[2] == 1'b0 && sfr_rdata[7] == 1'b0 && sfr_rdata[3] == 1'b0)
    else $error("control read shows write-only bits");
  a_irq_unused: assert property (sfr_req.rd && sfr_req.addr == ADDR_IRQ_CTRL
    |=> sfr_rdata[3:1] == 3'h0 && sfr_rdata[7:5] == 3'h0)
    else $error("interrupt control unused bits set");
endmodule : sleep_timer_props

bind sleep_timer sleep_timer_props #(.CAL_WIDTH(CAL_WIDTH)) u_sleep_timer_props (
  .clk(clk), .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .power_mode(power_mode), .fast_xosc_running(fast_xosc_running),
  .rc_cal_valid(rc_cal_valid), .rc_cal_result(rc_cal_result),
  .rc_cal_trim(rc_cal_trim), .wake_request(wake_request), .wake_irq(wake_irq),
  .wake_dma_trigger(wake_dma_trigger)
);

// file: src/sleep_edge_detect.sv
`timescale 1ns/10ps

// =========================================================================
// sleep clock synchroniser and rising edge detector
// =========================================================================
module sleep_edge_detect (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic sleep_clk_raw,
  output logic      rise
);

  logic sync1_q;
  logic sync2_q;
  logic last_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
    end else begin
      sync1_q <= sleep_clk_raw;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  assign rise = sync2_q & ~last_q;

endmodule : sleep_edge_detect

// file: src/sleep_timer.sv
`timescale 1ns/10ps

module sleep_timer
  import sleep_timer_pkg::*;
#(
  parameter int unsigned CAL_WIDTH = 6
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire sfr_req_s             sfr_req,
  output logic [7:0]                sfr_rdata,
  input  wire logic                 xosc_32k_in,
  input  wire logic                 low_power_rc_oscillator_in,
  input  wire logic                 sleep_clk_sel,
  input  wire power_mode_e          power_mode,
  input  wire logic                 fast_xosc_running,
  input  wire logic                 rc_cal_valid,
  input  wire logic [CAL_WIDTH-1:0] rc_cal_result,
  output logic [CAL_WIDTH-1:0]      rc_cal_trim,
  output logic                      wake_request,
  output logic                      wake_irq,
  output logic                      wake_dma_trigger
);

  // =======================================================================
  // helpers
  // =======================================================================
  function automatic logic [SLICE_WIDTH-1:0] slice_of(
    input logic [COUNT_WIDTH-1:0] count,
    input logic [RES_WIDTH-1:0]   res
  );
    logic [COUNT_WIDTH-1:0] shifted;
    shifted = count >> (RES_STEP * res);
    return shifted[SLICE_WIDTH-1:0];
  endfunction : slice_of

  function automatic logic may_sleep_count(input power_mode_e mode);
    return (mode != deepest_power_mode);
  endfunction : may_sleep_count

  function automatic logic is_light_sleep(input power_mode_e mode);
    return (mode == power_mode_zero) || (mode == power_mode_one) ||
           (mode == power_mode_two);
  endfunction : is_light_sleep

  // =======================================================================
  // state
  // =======================================================================
  typedef enum logic [0:0] {
    wake_idle,
    wake_pending
  } wake_state_e;

  logic [COUNT_WIDTH-1:0] count_q;
  logic [COUNT_WIDTH-1:0] count_inc;
  logic [RES_WIDTH-1:0]   res_q;
  logic [2:0]             ctrl_rsvd_q;
  logic [7:0]             evt_low_q;
  logic [7:0]             evt_high_q;
  logic                   irq_flag_q;
  logic                   irq_mask_q;
  logic [7:0]             cnt_high_shadow_q;
  logic [7:0]             rdata_q;
  logic                   wake_irq_q;
  logic                   dma_q;
  logic                   wake_request_q;
  logic [CAL_WIDTH-1:0]   rc_trim_q;
  wake_state_e            wake_state_q;

  logic                   sleep_clk_mux;
  logic                   sleep_rise;
  logic                   tick_run;
  logic [SLICE_WIDTH-1:0] evt_value;
  logic [SLICE_WIDTH-1:0] evt_written;
  logic [SLICE_WIDTH-1:0] slice_now;
  logic [SLICE_WIDTH-1:0] slice_next;
  logic                   wr_ctrl;
  logic                   wr_evt_low;
  logic                   wr_evt_high;
  logic                   wr_irq;
  logic                   ctrl_reset_write;
  logic                   match_tick;
  logic                   write_below;
  logic                   event_fire;

  // =======================================================================
  // sleep clock selection and crossing
  // =======================================================================
  // mux ahead of the first sync stage; a switch may cost one stray tick
  assign sleep_clk_mux = sleep_clk_sel ? xosc_32k_in : low_power_rc_oscillator_in;

  sleep_edge_detect u_edge (
    .clk           (clk),
    .reset         (reset),
    .sleep_clk_raw (sleep_clk_mux),
    .rise          (sleep_rise)
  );

  assign tick_run = sleep_rise && may_sleep_count(power_mode);

  // =======================================================================
  // register write decode
  // =======================================================================
  assign wr_ctrl     = sfr_req.wr && (sfr_req.addr == ADDR_CTRL);
  assign wr_evt_low  = sfr_req.wr && (sfr_req.addr == ADDR_EVT_LOW);
  assign wr_evt_high = sfr_req.wr && (sfr_req.addr == ADDR_EVT_HIGH);
  assign wr_irq      = sfr_req.wr && (sfr_req.addr == ADDR_IRQ_CTRL);

  assign ctrl_reset_write = wr_ctrl && sfr_req.wdata[CTRL_RESET_BIT];

  // =======================================================================
  // event detection
  // =======================================================================
  assign evt_value  = {evt_high_q, evt_low_q};
  assign count_inc  = count_q + 1'b1;
  assign slice_now  = slice_of(count_q, res_q);
  assign slice_next = slice_of(count_inc, res_q);

  // value that the event register holds after this write
  always_comb begin
    evt_written = evt_value;
    if (wr_evt_low) begin
      evt_written = {evt_high_q, sfr_req.wdata};
    end else if (wr_evt_high) begin
      evt_written = {sfr_req.wdata, evt_low_q};
    end
  end

  // interval is mantissa slice steps, each 2^(5*res) periods
  assign match_tick = tick_run && (slice_next >= evt_value);

  assign write_below = (wr_evt_low || wr_evt_high) && may_sleep_count(power_mode) &&
                       (evt_written < slice_now);

  assign event_fire = (match_tick || write_below) && !ctrl_reset_write;

  // =======================================================================
  // sleep counter
  // =======================================================================
  // resolution is not part of the count; changing it only moves the slice
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= COUNT_POWERUP;
    end else if (ctrl_reset_write) begin
      count_q <= COUNT_RESET_VALUE;
    end else if (event_fire) begin
      count_q <= COUNT_POWERUP;
    end else if (tick_run) begin
      count_q <= count_inc;
    end
  end

  // =======================================================================
  // control and event value registers
  // =======================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      res_q       <= RES_RESET;
      ctrl_rsvd_q <= CTRL_RSVD_RESET;
    end else if (wr_ctrl) begin
      res_q       <= sfr_req.wdata[CTRL_RES_LSB +: RES_WIDTH];
      ctrl_rsvd_q <= sfr_req.wdata[CTRL_RSVD_LSB +: 3];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evt_low_q  <= EVT_LOW_RESET;
      evt_high_q <= EVT_HIGH_RESET;
    end else begin
      if (wr_evt_low) begin
        evt_low_q <= sfr_req.wdata;
      end
      if (wr_evt_high) begin
        evt_high_q <= sfr_req.wdata;
      end
    end
  end

  // =======================================================================
  // interrupt flag and mask
  // =======================================================================
  // a new event wins over a clearing write in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_flag_q <= 1'b0;
    end else if (event_fire) begin
      irq_flag_q <= 1'b1;
    end else if (wr_irq && !sfr_req.wdata[IRQ_FLAG_BIT]) begin
      irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_mask_q <= 1'b0;
    end else if (wr_irq) begin
      irq_mask_q <= sfr_req.wdata[IRQ_MASK_BIT];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_irq_q <= 1'b0;
    end else begin
      wake_irq_q <= irq_flag_q && irq_mask_q;
    end
  end

  // =======================================================================
  // dma trigger
  // =======================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dma_q <= 1'b0;
    end else begin
      dma_q <= event_fire;
    end
  end

  // =======================================================================
  // wake request toward the power controller
  // =======================================================================
  // held until the power controller reports active mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_state_q   <= wake_idle;
      wake_request_q <= 1'b0;
    end else begin
      case (wake_state_q)
        wake_idle: begin
          if (event_fire && is_light_sleep(power_mode)) begin
            wake_state_q   <= wake_pending;
            wake_request_q <= 1'b1;
          end
        end
        wake_pending: begin
          if (power_mode == pm_active) begin
            wake_state_q   <= wake_idle;
            wake_request_q <= 1'b0;
          end
        end
        default: begin
          wake_state_q   <= wake_idle;
          wake_request_q <= 1'b0;
        end
      endcase
    end
  end

  // =======================================================================
  // rc oscillator calibration hold
  // =======================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rc_trim_q <= '0;
    end else if (rc_cal_valid && fast_xosc_running &&
                 ((power_mode == pm_active) || (power_mode == power_mode_zero))) begin
      rc_trim_q <= rc_cal_result;
    end
  end

  // =======================================================================
  // register read
  // =======================================================================
  // low byte read freezes the high byte so a low-then-high pair matches
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_high_shadow_q <= BYTE_ZERO;
    end else if (sfr_req.rd && (sfr_req.addr == ADDR_CNT_LOW)) begin
      cnt_high_shadow_q <= slice_now[15:8];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= BYTE_ZERO;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        ADDR_IRQ_CTRL: begin
          rdata_q                <= BYTE_ZERO;
          rdata_q[IRQ_MASK_BIT]  <= irq_mask_q;
          rdata_q[IRQ_FLAG_BIT]  <= irq_flag_q;
        end
        ADDR_CTRL: begin
          rdata_q                              <= BYTE_ZERO;
          rdata_q[CTRL_RES_LSB +: RES_WIDTH]   <= res_q;
          rdata_q[CTRL_RSVD_LSB +: 3]          <= ctrl_rsvd_q;
        end
        ADDR_EVT_LOW: begin
          rdata_q <= evt_low_q;
        end
        ADDR_EVT_HIGH: begin
          rdata_q <= evt_high_q;
        end
        ADDR_CNT_LOW: begin
          rdata_q <= slice_now[7:0];
        end
        ADDR_CNT_HIGH: begin
          rdata_q <= cnt_high_shadow_q;
        end
        default: begin
          rdata_q <= BYTE_ZERO;
        end
      endcase
    end else begin
      rdata_q <= BYTE_ZERO;
    end
  end

  // =======================================================================
  // outputs
  // =======================================================================
  assign sfr_rdata        = rdata_q;
  assign wake_irq         = wake_irq_q;
  assign wake_dma_trigger = dma_q;
  assign wake_request     = wake_request_q;
  assign rc_cal_trim      = rc_trim_q;

endmodule : sleep_timer

// file: src/sleep_timer_pkg.sv
package sleep_timer_pkg;

  // =======================================================================
  // register addresses
  // =======================================================================
  localparam logic [7:0] ADDR_IRQ_CTRL  = 8'hA1;
  localparam logic [7:0] ADDR_CTRL      = 8'hA2;
  localparam logic [7:0] ADDR_EVT_LOW   = 8'hA3;
  localparam logic [7:0] ADDR_EVT_HIGH  = 8'hA4;
  localparam logic [7:0] ADDR_CNT_LOW   = 8'hA5;
  localparam logic [7:0] ADDR_CNT_HIGH  = 8'hA6;

  // =======================================================================
  // widths and counter constants
  // =======================================================================
  localparam int unsigned COUNT_WIDTH = 31;
  localparam int unsigned SLICE_WIDTH = 16;
  localparam int unsigned RES_WIDTH   = 2;
  localparam int unsigned RES_STEP    = 5;

  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET_VALUE = 31'h0000_0004;
  localparam logic [COUNT_WIDTH-1:0] COUNT_POWERUP     = 31'h0000_0000;

  // =======================================================================
  // reset values
  // =======================================================================
  localparam logic [7:0]           EVT_LOW_RESET   = 8'h6B;
  localparam logic [7:0]           EVT_HIGH_RESET  = 8'h87;
  localparam logic [2:0]           CTRL_RSVD_RESET = 3'h7;
  localparam logic [RES_WIDTH-1:0] RES_RESET       = 2'h0;
  localparam logic [7:0]           BYTE_ZERO       = 8'h00;

  // =======================================================================
  // field positions
  // =======================================================================
  localparam int unsigned CTRL_RES_LSB   = 0;
  localparam int unsigned CTRL_RESET_BIT = 2;
  localparam int unsigned CTRL_RSVD_LSB  = 4;
  localparam int unsigned IRQ_FLAG_BIT   = 0;
  localparam int unsigned IRQ_MASK_BIT   = 4;

  // =======================================================================
  // types
  // =======================================================================
  typedef enum logic [2:0] {
    pm_active,
    power_mode_zero,
    power_mode_one,
    power_mode_two,
    deepest_power_mode
  } power_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

endpackage : sleep_timer_pkg
